// [rtl/msrc_ctrl.sv]
// Purpose: measurement rate decode and magnetic sensor reset control
// Assumes: register port driven by the serial interface logic on the same clock
// Notes:   read data appears one cycle after the read strobe
//
// What this block does
// - converter rate 1280/640/320/160 Hz for codes 0-3, 80 Hz for codes 4 up.
// - oversampling ratio 16/32/64/128 from its field, independent of rate field.
// - output rate per table; each rate step above 4 halves it at 80 Hz.
// - auto-reset enable set runs a sensor reset cycle before each acquisition.
// - auto-reset enable is write-only and always reads back as 0.
// - raw-select 0 applies user offsets, 1 delivers data without them.
// - factory calibration is always applied regardless of raw-select.
// - host writes 1 to manual reset bit; it reads 1 while cycle runs.
// - manual reset bit clears itself when the reset cycle completes.
// - auto, raw-select and manual reset bits are 0 after reset.
// - raw-select 0 subtracts per-axis user offsets with bit 0 cleared, unclipped, before storing data.
`timescale 1ns/100ps
`include "msrc_regs.svh"

module msrc_ctrl
   import msrc_pkg::*;
#(
   parameter int CONV_BASE_CYC = `MSRC_CONV_BASE_CYC,
   parameter int SRST_CYC      = `MSRC_SRST_CYC
)
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  msrc_axes_t       raw_data,
   input  msrc_axes_t       fact_off,
   input  msrc_axes_t       user_off,
   output logic             conv_strobe,
   output logic      [7:0]  oversampling_ratio,
   output logic      [2:0]  conv_rate_shift,
   output logic             sensor_reset_active,
   output logic             sample_strobe,
   output msrc_axes_t       mag_data
);

   localparam logic [`MSRC_CNT_W-1:0]  BASE_CYC = `MSRC_CNT_W'(CONV_BASE_CYC);
   localparam logic [`MSRC_SRST_W-1:0] SRST_END = `MSRC_SRST_W'(SRST_CYC - 1);

   msrc_state_t q;
   msrc_state_t d;
   msrc_axes_t  corr;
   logic [2:0]  rate_code;
   logic [1:0]  os_code;
   logic [2:0]  dec_shift;
   logic [2:0]  conv_shift;
   logic [`MSRC_CNT_W-1:0] period;
   logic [`MSRC_NUM_W-1:0] nconv;
   logic        acquire;
   logic        active;
   logic        conv_last;
   logic        acq_last;
   logic        srst_done;
   logic        wr_src;
   logic        mrst_start;
   logic [`MSRC_CNT_W-1:0]  conv_inc;
   logic [`MSRC_NUM_W-1:0]  num_inc;
   logic [`MSRC_SRST_W-1:0] srst_inc;

   // =====================================================================
   // offset correction per axis
   genvar ax;
   generate
      for (ax = 0; ax < 3; ax++) begin : g_axis
         msrc_axis_corr u_corr (
            .raw      (raw_data[ax]),
            .fact_off (fact_off[ax]),
            .user_off (user_off[ax]),
            .raw_sel  (q.raw_sel),
            .corr     (corr[ax])
         );
      end
   endgenerate

   // =====================================================================
   // rate decode
   always_comb begin
      rate_code  = q.rate_ctrl[`MSRC_RATE_MSB:`MSRC_RATE_LSB];
      os_code    = q.rate_ctrl[`MSRC_OS_MSB:`MSRC_OS_LSB];
      conv_shift = (rate_code >= `MSRC_SLOW_CODE) ? `MSRC_SLOW_CODE : rate_code;
      dec_shift  = (rate_code >= `MSRC_SLOW_CODE) ? 3'(rate_code - `MSRC_SLOW_CODE)
                                                  : 3'h0;
      period     = `MSRC_CNT_W'(BASE_CYC << conv_shift);
      nconv      = `MSRC_NUM_W'((`MSRC_CONV_NUM_BASE << os_code) << dec_shift);
   end

   // =====================================================================
   // event decode
   // >= keeps a period shortened while active from overrunning its counter
   always_comb begin
      active     = q.rate_ctrl[`MSRC_ACTIVE_BIT];
      conv_last  = (q.conv_cnt >= period - `MSRC_CNT_W'(1));
      acq_last   = (q.conv_num >= nconv - `MSRC_NUM_W'(1));
      srst_done  = q.srst_busy && (q.srst_cnt == SRST_END);
      wr_src     = reg_wr && (reg_addr == `MSRC_SRC_CTRL_ADDR);
      mrst_start = wr_src && reg_wdata[`MSRC_MRST_BIT];
      conv_inc   = `MSRC_CNT_W'(q.conv_cnt + `MSRC_CNT_W'(1));
      num_inc    = `MSRC_NUM_W'(q.conv_num + `MSRC_NUM_W'(1));
      srst_inc   = `MSRC_SRST_W'(q.srst_cnt + `MSRC_SRST_W'(1));
   end

   // =====================================================================
   // next state
   always_comb begin
      d            = q;
      d.conv_stb   = 1'b0;
      d.sample_stb = 1'b0;
      acquire      = 1'b0;

      // conversion pacing, idle in standby
      if (!active) begin
         d.conv_cnt = '0;
         d.conv_num = '0;
      end else if (conv_last) begin
         d.conv_cnt = '0;
         d.conv_stb = 1'b1;
         if (acq_last) begin
            d.conv_num = '0;
            acquire    = 1'b1;
         end else begin
            d.conv_num = num_inc;
         end
      end else begin
         d.conv_cnt = conv_inc;
      end

      // sensor reset cycle
      if (q.srst_busy) begin
         if (srst_done) begin
            d.srst_busy = 1'b0;
            d.srst_cnt  = '0;
            if (q.srst_pend) begin
               d.srst_pend  = 1'b0;
               d.data       = corr;
               d.sample_stb = 1'b1;
            end
         end else begin
            d.srst_cnt = srst_inc;
         end
      end

      // acquisition, preceded by a reset cycle when enabled
      if (acquire) begin
         if (q.auto_en) begin
            d.srst_busy = 1'b1;
            d.srst_pend = 1'b1;
         end else begin
            d.data       = corr;
            d.sample_stb = 1'b1;
         end
      end

      // register writes; a start wins over completion
      if (reg_wr) begin
         unique case (reg_addr)
            `MSRC_RATE_CTRL_ADDR: begin
               d.rate_ctrl = reg_wdata;
            end
            `MSRC_SRC_CTRL_ADDR: begin
               d.auto_en = reg_wdata[`MSRC_AUTO_BIT];
               d.raw_sel = reg_wdata[`MSRC_RAW_BIT];
               if (mrst_start) begin
                  d.srst_busy = 1'b1;
                  if (!q.srst_busy) begin
                     d.srst_cnt = '0;
                  end
               end
            end
            default: begin
            end
         endcase
      end

      // register reads
      if (reg_rd) begin
         d.rdata = 8'h00;
         unique case (reg_addr)
            `MSRC_RATE_CTRL_ADDR: begin
               d.rdata = q.rate_ctrl;
            end
            `MSRC_SRC_CTRL_ADDR: begin
               d.rdata[`MSRC_AUTO_BIT] = 1'b0;
               d.rdata[`MSRC_RAW_BIT]  = q.raw_sel;
               d.rdata[`MSRC_MRST_BIT] = q.srst_busy;
            end
            default: begin
            end
         endcase
      end
   end

   // =====================================================================
   // state register
   always_ff @(posedge clock) begin
      if (rst) begin
         q            <= '0;
         q.rate_ctrl  <= `MSRC_RATE_CTRL_RST;
         q.auto_en    <= `MSRC_SRC_CTRL_RST;
         q.raw_sel    <= `MSRC_SRC_CTRL_RST;
         q.srst_busy  <= `MSRC_SRC_CTRL_RST;
      end else begin
         q <= d;
      end
   end

   // =====================================================================
   // outputs
   always_comb begin
      reg_rdata           = q.rdata;
      conv_strobe         = q.conv_stb;
      oversampling_ratio  = 8'(`MSRC_OSR_BASE << os_code);
      conv_rate_shift     = conv_shift;
      sensor_reset_active = q.srst_busy;
      sample_strobe       = q.sample_stb;
      mag_data            = q.data;
   end

endmodule

// [rtl/msrc_regs.svh]
// Purpose: register offsets, field positions, reset values and timing figures of the
//          measurement rate and sensor-reset control block
// Assumes: 8-bit register addresses and data
// Notes:   definitions only
`ifndef MSRC_REGS_SVH
`define MSRC_REGS_SVH

// =====================================================================
// register offsets
`define MSRC_RATE_CTRL_ADDR   8'h10
`define MSRC_SRC_CTRL_ADDR    8'h11

// =====================================================================
// rate_and_mode_control fields
`define MSRC_RATE_MSB         7
`define MSRC_RATE_LSB         5
`define MSRC_OS_MSB           4
`define MSRC_OS_LSB           3
`define MSRC_ACTIVE_BIT       0
`define MSRC_RATE_CTRL_RST    8'h00

// =====================================================================
// sensor_reset_and_correction_control fields
`define MSRC_AUTO_BIT         7
`define MSRC_RAW_BIT          5
`define MSRC_MRST_BIT         4
`define MSRC_SRC_CTRL_RST     1'b0

// =====================================================================
// rate decoding
`define MSRC_SLOW_CODE        3'h4
`define MSRC_OSR_BASE         8'h10
`define MSRC_CONV_NUM_BASE    11'h010

// =====================================================================
// timing
`define MSRC_CLK_HZ           40000000
`define MSRC_CONV_FAST_HZ     1280
`define MSRC_CONV_BASE_CYC    (`MSRC_CLK_HZ / `MSRC_CONV_FAST_HZ)
`define MSRC_SRST_CYC         16

// =====================================================================
// counter widths
`define MSRC_CNT_W            20
`define MSRC_NUM_W            11
`define MSRC_SRST_W           16

`endif

// [rtl/msrc_pkg.sv]
// Purpose: shared types of the measurement rate and sensor-reset control block
// Assumes: widths from msrc_regs.svh
// Notes:   three axes x, y, z at index 0, 1, 2
`include "msrc_regs.svh"

package msrc_pkg;

   // =====================================================================
   // per-axis data
   typedef logic [2:0][15:0] msrc_axes_t;

   // =====================================================================
   // block state
   typedef struct packed {
      logic [7:0]               rate_ctrl;
      logic                     auto_en;
      logic                     raw_sel;
      logic                     srst_busy;
      logic                     srst_pend;
      logic [`MSRC_SRST_W-1:0]  srst_cnt;
      logic [`MSRC_CNT_W-1:0]   conv_cnt;
      logic [`MSRC_NUM_W-1:0]   conv_num;
      logic                     conv_stb;
      logic                     sample_stb;
      logic [7:0]               rdata;
      msrc_axes_t               data;
   } msrc_state_t;

endpackage

// [rtl/msrc_axis_corr.sv]
// Purpose: offset correction of one axis
// Assumes: samples and offsets in two's complement
// Notes:   result wraps, no clipping
`timescale 1ns/100ps

module msrc_axis_corr
   import msrc_pkg::*;
(
   input  wire logic [15:0] raw,
   input  wire logic [15:0] fact_off,
   input  wire logic [15:0] user_off,
   input  wire logic        raw_sel,
   output logic      [15:0] corr
);

   logic [15:0] user_term;

   // =====================================================================
   // correction
   always_comb begin
      user_term = raw_sel ? 16'h0000 : {user_off[15:1], 1'b0};
      corr      = 16'(raw - fact_off - user_term);
   end

endmodule

// [tb/msrc_ctrl_sva.sv]
// Purpose: port checks of msrc_ctrl
// Assumes: the control shadow is rebuilt from writes seen on the port
// Notes:   sh_q[9] auto, sh_q[8] raw select, sh_q[7:0] rate control
`timescale 1ns/100ps
module msrc_ctrl_sva
   import msrc_pkg::*;
#(
   parameter int CONV_BASE_CYC = 4,
   parameter int SRST_CYC      = 4
)
(
   input wire logic       clock,
   input wire logic       rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire msrc_axes_t raw_data,
   input wire msrc_axes_t fact_off,
   input wire msrc_axes_t user_off,
   input wire logic       conv_strobe,
   input wire logic [7:0] oversampling_ratio,
   input wire logic [2:0] conv_rate_shift,
   input wire logic       sensor_reset_active,
   input wire logic       sample_strobe,
   input wire msrc_axes_t mag_data
);
   // ==========
   // shadows
   logic [9:0] sh_q;
   msrc_axes_t exp_v;
   int         srst_run;
   logic       mrst_wr_q;
   always_ff @(posedge clock) begin
      mrst_wr_q <= reg_wr && reg_addr == 8'h11 && reg_wdata[4];
      if (rst || !sensor_reset_active)
         srst_run <= 0;
      else
         srst_run <= srst_run + 1;
   end
   always_ff @(posedge clock) begin
      if (rst)
         sh_q <= 10'h000;
      else if (reg_wr && reg_addr == 8'h10)
         sh_q[7:0] <= reg_wdata;
      else if (reg_wr && reg_addr == 8'h11)
         sh_q[9:8] <= {reg_wdata[7], reg_wdata[5]};
   end
   always_comb begin
      for (int a = 0; a < 3; a++)
         exp_v[a] = raw_data[a] - fact_off[a] - (sh_q[8] ? 16'h0000 : (user_off[a] & 16'hfffe));
   end
   // ==========
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   chk_osr_map: assert property (oversampling_ratio == (8'h10 << sh_q[4:3])) else $error("osr");
   chk_rate_map: assert property (conv_rate_shift == (sh_q[7] ? 3'h4 : sh_q[7:5])) else $error("rate");
   chk_rd_ctrl2: assert property (reg_rd && reg_addr == 8'h11 |=>
      reg_rdata == {2'h0, $past(sh_q[8]), $past(sensor_reset_active), 4'h0}) else $error("ctrl2 read");
   chk_mrst_go: assert property (reg_wr && reg_addr == 8'h11 && reg_wdata[4] |=>
      sensor_reset_active) else $error("no start");
   chk_mrst_len: assert property ($fell(sensor_reset_active) |->
      srst_run != 0 && srst_run % SRST_CYC == 0) else $error("reset length");
   chk_smp_plain: assert property (sample_strobe && !sh_q[9] |->
      conv_strobe) else $error("plain sample");
   chk_rst_cause: assert property ($rose(sensor_reset_active) |->
      mrst_wr_q || (sh_q[9] && conv_strobe)) else $error("stray reset");
   chk_smp_auto: assert property (sample_strobe && sh_q[9] |->
      $past(sensor_reset_active) && !sensor_reset_active) else $error("auto sample");
   chk_data_out: assert property (sample_strobe |-> mag_data == $past(exp_v)) else $error("data");
   cover property (sample_strobe && sh_q[9]);
   cover property ($fell(sensor_reset_active));
   cover property (reg_rd && reg_addr == 8'h11 && sensor_reset_active);
endmodule
bind msrc_ctrl msrc_ctrl_sva #(.CONV_BASE_CYC(CONV_BASE_CYC), .SRST_CYC(SRST_CYC)) chk_i (
   .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .raw_data(raw_data), .fact_off(fact_off),
   .user_off(user_off), .conv_strobe(conv_strobe), .oversampling_ratio(oversampling_ratio),
   .conv_rate_shift(conv_rate_shift), .sensor_reset_active(sensor_reset_active),
   .sample_strobe(sample_strobe), .mag_data(mag_data));

// [tb/msrc_host.sv]
// Purpose: register host model
// Assumes: one-cycle strobes, requests from the clock edge
// Notes:   address and data are scrambled once released
`timescale 1ns/100ps
module msrc_host (
   input  wire logic       clock,
   input  wire logic [7:0] reg_rdata,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd
);
   initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
   // callers keep the device in standby while rate fields change
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1 d = reg_rdata;
   endtask
endmodule

// [tb/mag_sample_rate_and_reset_ctrl_tb.sv]
// Purpose: self-checking bench of msrc_ctrl
// Assumes: CONV_BASE_CYC 4, SRST_CYC 4
// Notes:   host model drives the register port
`timescale 1ns/100ps
module mag_sample_rate_and_reset_ctrl_tb;
   import msrc_pkg::*;
   logic       clock = 1'b0;
   logic       rst = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, oversampling_ratio;
   logic       reg_wr, reg_rd, conv_strobe, sensor_reset_active, sample_strobe;
   logic [2:0] conv_rate_shift;
   msrc_axes_t raw_data, fact_off, user_off, mag_data;
   int         err_total = 0;
   int         checks_done = 0;
   int         cyc = 0;
   always #12.5 clock = ~clock;
   msrc_ctrl #(.CONV_BASE_CYC(4), .SRST_CYC(4)) uut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .raw_data(raw_data),
      .fact_off(fact_off), .user_off(user_off), .conv_strobe(conv_strobe), .oversampling_ratio(oversampling_ratio),
      .conv_rate_shift(conv_rate_shift), .sensor_reset_active(sensor_reset_active),
      .sample_strobe(sample_strobe), .mag_data(mag_data));
   msrc_host host (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd));
   // ==========
   // helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("mismatches %0d comparisons %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         end_sim();
      end
   end
   // ==========
   // scenarios
   task automatic t_reset;
      logic [7:0] d;
      host.rd(8'h11, d);
      chk(16'(d), 16'h0000);
      host.rd(8'h3c, d);
      chk(16'(d), 16'h0000);
      host.wr(8'h11, 8'hef);
      host.rd(8'h11, d);
      chk(16'(d), 16'h0020);
   endtask
   task automatic t_mrst;
      logic [7:0] d;
      host.wr(8'h11, 8'h30);
      host.rd(8'h11, d);
      chk(16'(d), 16'h0030);
      for (int i = 0; i < 50 && sensor_reset_active === 1'b1; i++) begin
         @(posedge clock);
         #1;
      end
      host.rd(8'h11, d);
      chk(16'(d), 16'h0020);
   endtask
   task automatic t_rerun;
      logic [7:0] d;
      host.wr(8'h11, 8'h30);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      host.rd(8'h11, d);
      chk(16'(d), 16'h0000);
      chk(16'(sensor_reset_active), 16'h0000);
   endtask
   task automatic t_decode;
      for (int i = 0; i < 32; i++) begin
         host.wr(8'h10, 8'(i << 3));
         #1;
         chk(16'(oversampling_ratio), 16'h0010 << i[1:0]);
         chk(16'(conv_rate_shift), (i >= 16) ? 16'h0004 : 16'(i >> 2));
      end
   endtask
   task automatic t_meas(input logic [7:0] c2, input logic [7:0] rc, input int n_exp, input int cyc_exp);
      int n;
      int w;
      logic seen;
      n = 0;
      w = 0;
      seen = 1'b0;
      host.wr(8'h11, c2);
      host.wr(8'h10, rc);
      host.wr(8'h10, rc | 8'h01);
      for (int i = 0; i < 6000 && sample_strobe !== 1'b1; i++) begin
         @(posedge clock);
         #1;
         w++;
         if (!seen)
            n += (conv_strobe === 1'b1);
         seen |= (sensor_reset_active === 1'b1);
      end
      chk(16'(n), 16'(n_exp));
      chk(16'(w), 16'(cyc_exp));
      chk(16'(seen), 16'(c2[7]));
      for (int a = 0; a < 3; a++)
         chk(mag_data[a], raw_data[a] - fact_off[a] - (c2[5] ? 16'h0 : user_off[a] & 16'hfffe));
      host.wr(8'h10, rc);
   endtask
   initial begin
      raw_data = {16'h8000, 16'h0100, 16'h1000};
      fact_off = {3{16'h0010}};
      user_off = {3{16'h0203}};
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      t_reset();
      t_mrst();
      t_rerun();
      t_decode();
      t_meas(8'h20, 8'h00, 16, 64);
      t_meas(8'h00, 8'h08, 32, 128);
      t_meas(8'h20, 8'ha0, 32, 2048);
      t_meas(8'ha0, 8'h00, 16, 68);
      end_sim();
   end
endmodule
